// File: design/ppm_timer_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the timer
// Assumes: Included by the package and by the timer top module
// Notes: Definitions only
`ifndef PPM_TIMER_DEFINES_SVH
`define PPM_TIMER_DEFINES_SVH

// Register byte offsets on the bus
`define PPM_ADR_MODE 8'h00
`define PPM_ADR_START 8'h04
`define PPM_ADR_DATA 8'h08
`define PPM_ADR_IRQ 8'h0C
`define PPM_ADR_PRESC 8'h10

// Field positions
`define PPM_MODE_OP_LSB 0
`define PPM_MODE_SUB_LSB 2
`define PPM_MODE_RSV_BIT 4
`define PPM_MODE_OVF_BIT 5
`define PPM_MODE_CKS_LSB 6
`define PPM_START_RUN_BIT 0
`define PPM_IRQ_REQ_BIT 0

// Widths and reset values
`define PPM_CNT_W 16
`define PPM_CNT_MAX 16'hFFFF
`define PPM_CNT_ZERO 16'h0000
`define PPM_MODE_RST 8'h00
`define PPM_PRESC_RST 8'h01

// Timing counts
`define PPM_DIV8_LAST 3'h7

`endif

// File: design/ppm_timer_pkg.sv
// Purpose: Types shared by the pulse measurement timer files
// Assumes: Constants come from the defines header
// Notes: Mode register layout is a packed struct, msb first
`include "ppm_timer_defines.svh"

package ppm_timer_pkg;

  typedef enum logic [1:0] {
    OP_TIMER = 2'b00,
    OP_EVENT = 2'b01,
    OP_MEASURE = 2'b10,
    OP_ONESHOT = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    CS_UNDIV = 2'b00,
    CS_DIV8 = 2'b01,
    CS_PROG = 2'b10,
    CS_SUB = 2'b11
  } clk_src_t;

  typedef enum logic [1:0] {
    SM_PERIOD_FALL = 2'b00,
    SM_PERIOD_RISE = 2'b01,
    SM_WIDTH = 2'b10,
    SM_PROHIBITED = 2'b11
  } sub_mode_t;

  typedef struct packed {
    clk_src_t cks;
    logic ovf;
    logic rsv;
    sub_mode_t sub;
    op_mode_t op;
  } mode_reg_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync3_t;

  typedef struct packed {
    mode_reg_t mode;
    logic run;
    logic irq;
    logic ovf_aged;
    logic seen_edge;
    logic [`PPM_CNT_W-1:0] cnt;
    logic [7:0] presc;
    logic [2:0] div8;
    logic [8:0] divn;
    sync3_t pin;
    sync3_t sub;
    logic ack;
    logic [31:0] rdata;
  } state_t;

endpackage

// File: design/meas_reload_reg.sv
// Purpose: Reload register holding the latest pulse measurement
// Assumes: Capture strobe and data come from the same clock domain
// Notes: Read data come straight out of the stored register
`timescale 1ns/1ps

module meas_reload_reg #(
  parameter int W = 16
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Capture side
  input wire logic cap_i,
  input wire logic [W-1:0] cap_data_i,
  // Read side
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] val;
  } rl_state_t;

  rl_state_t st_q;
  rl_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (cap_i) begin
      st_d.val = cap_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.val;

endmodule // meas_reload_reg

// File: design/pulse_period_width_measure_timer.sv
// Purpose: One 16-bit timer channel in pulse period / pulse width measure
//          mode, with its registers on a classic Wishbone slave
// Assumes: Pulse and sub clock inputs are asynchronous to clk_i
// Notes: Other operating modes of the channel are not implemented
//
// Functional notes
// - Two-bit field picks one of four count clocks
// - Count up; valid edge captures, clears, continues
// - Count only while the run bit is one
// - Request on valid edges except the first
// - Overflow sets flag and raises a request
// - Data register reads the reload register
// - First captured value is undefined
// - Data register writes are ignored
// - Mode write while running after aged overflow clears flag
// - Overflow flag cannot be set by software
// - Operating mode one-zero selects measurement
// - Sub-mode selects period one, two, or width
// - Width mode: every edge valid, alternating levels
// - Undefined start count may overflow early
// - Changed sub-mode while running may request
// - Overflow with edge: one request, edge lost
// - Stopped after reset; configure while stopped
`timescale 1ns/1ps
`include "ppm_timer_defines.svh"

module pulse_period_width_measure_timer #(
  parameter int CNT_W = `PPM_CNT_W
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire ppm_timer_pkg::wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // External pins
  input wire logic pulse_input_pin_i,
  input wire logic low_speed_sub_clk_i,
  // Interrupt request flag
  output logic irq_request_flag_o
);

  ppm_timer_pkg::state_t st_q;
  ppm_timer_pkg::state_t st_d;

  logic cap;
  logic [CNT_W-1:0] reload_q;

  // Byte lane zero carries every narrow register
  function automatic logic wr_hit(
    input ppm_timer_pkg::wb_req_t req,
    input logic [7:0] adr
  );
    wr_hit = req.we && req.adr == adr && req.sel[0];
  endfunction

  // Three-flop input stage; the level moves once flops two and three agree
  function automatic ppm_timer_pkg::sync3_t sync_step(
    input ppm_timer_pkg::sync3_t s,
    input logic pin
  );
    ppm_timer_pkg::sync3_t n;
    n.s1 = pin;
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.lvl = (s.s2 == s.s3) ? s.s3 : s.lvl;
    sync_step = n;
  endfunction

  always_comb begin
    logic acc;
    logic do_wr;
    logic tick;
    logic rise;
    logic fall;
    logic vedge;
    logic ovf_evt;
    logic counting;
    logic [8:0] lim;
    ppm_timer_pkg::mode_reg_t wmode;
    acc = 1'b0;
    do_wr = 1'b0;
    tick = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    vedge = 1'b0;
    ovf_evt = 1'b0;
    counting = 1'b0;
    lim = 9'h001;
    wmode = ppm_timer_pkg::mode_reg_t'(wb_req_i.dat[7:0]);
    cap = 1'b0;
    st_d = st_q;

    // Input synchronisers and edge detection on the filtered level
    st_d.pin = sync_step(st_q.pin, pulse_input_pin_i);
    st_d.sub = sync_step(st_q.sub, low_speed_sub_clk_i);
    rise = st_d.pin.lvl && !st_q.pin.lvl;
    fall = !st_d.pin.lvl && st_q.pin.lvl;

    // Bus handshake: ack one cycle after the request, drop it next cycle
    acc = wb_req_i.cyc && wb_req_i.stb && !st_q.ack;
    do_wr = acc && wb_req_i.we;
    st_d.ack = acc;
    if (acc) begin
      case (wb_req_i.adr)
        `PPM_ADR_MODE: st_d.rdata = {24'h00_0000, st_q.mode};
        `PPM_ADR_START: st_d.rdata = {31'h0000_0000, st_q.run};
        `PPM_ADR_DATA: st_d.rdata = {16'h0000, reload_q};
        `PPM_ADR_IRQ: st_d.rdata = {31'h0000_0000, st_q.irq};
        `PPM_ADR_PRESC: st_d.rdata = {24'h00_0000, st_q.presc};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes
    if (do_wr && wr_hit(wb_req_i, `PPM_ADR_MODE)) begin
      st_d.mode.op = wmode.op;
      st_d.mode.sub = wmode.sub;
      st_d.mode.cks = wmode.cks;
      st_d.mode.rsv = 1'b0;
      // Flag bit of the written value is dropped
      if (st_q.run && st_q.ovf_aged) begin
        st_d.mode.ovf = 1'b0;
        st_d.ovf_aged = 1'b0;
      end
      // Retuning the edge selection mid-run looks like a fresh edge
      if (st_q.run && wmode.sub != st_q.mode.sub) begin
        st_d.irq = 1'b1;
      end
    end
    if (do_wr && wr_hit(wb_req_i, `PPM_ADR_START)) begin
      st_d.run = wb_req_i.dat[`PPM_START_RUN_BIT];
    end
    if (do_wr && wr_hit(wb_req_i, `PPM_ADR_IRQ)) begin
      // Software may only clear the request; writing one leaves it
      st_d.irq = st_q.irq && wb_req_i.dat[`PPM_IRQ_REQ_BIT];
    end
    if (do_wr && wr_hit(wb_req_i, `PPM_ADR_PRESC)) begin
      st_d.presc = wb_req_i.dat[7:0];
    end
    // Data register writes have no effect in this mode

    // A new run always waits for its first edge again
    if (!st_q.run) begin
      st_d.seen_edge = 1'b0;
    end

    // Count clock selection
    counting = st_q.run && st_q.mode.op == ppm_timer_pkg::OP_MEASURE;
    if (st_q.presc != 8'h00) begin
      lim = {st_q.presc, 1'b0} - 9'h001;
    end
    case (st_q.mode.cks)
      ppm_timer_pkg::CS_UNDIV: tick = 1'b1;
      ppm_timer_pkg::CS_DIV8: tick = st_q.div8 == `PPM_DIV8_LAST;
      ppm_timer_pkg::CS_PROG: tick = st_q.divn >= lim;
      ppm_timer_pkg::CS_SUB: tick = st_d.sub.lvl && !st_q.sub.lvl;
      default: tick = 1'b0;
    endcase
    if (counting) begin
      st_d.div8 = st_q.div8 + 3'h1;
      st_d.divn = (st_q.divn >= lim) ? 9'h000 : st_q.divn + 9'h001;
    end else begin
      st_d.div8 = 3'h0;
      st_d.divn = 9'h000;
    end

    // Valid edge of the measured pulse
    case (st_q.mode.sub)
      ppm_timer_pkg::SM_PERIOD_FALL: vedge = fall;
      ppm_timer_pkg::SM_PERIOD_RISE: vedge = rise;
      ppm_timer_pkg::SM_WIDTH: vedge = rise || fall;
      default: vedge = 1'b0;
    endcase

    // Count, capture and overflow; hardware sets land after bus clears
    if (counting) begin
      ovf_evt = tick && st_q.cnt == `PPM_CNT_MAX;
      if (ovf_evt) begin
        // An edge in this cycle is swallowed by the overflow
        st_d.cnt = `PPM_CNT_ZERO;
        st_d.mode.ovf = 1'b1;
        st_d.ovf_aged = 1'b0;
        st_d.irq = 1'b1;
      end else if (vedge) begin
        // First capture holds whatever the counter started from
        cap = 1'b1;
        st_d.cnt = `PPM_CNT_ZERO;
        st_d.seen_edge = 1'b1;
        if (st_q.seen_edge) begin
          st_d.irq = 1'b1;
        end
      end else if (tick) begin
        st_d.cnt = st_q.cnt + 16'h0001;
      end
      // One whole count period must pass before the flag may be cleared
      if (st_q.mode.ovf && tick && !ovf_evt) begin
        st_d.ovf_aged = 1'b1;
      end
    end
  end

  meas_reload_reg #(
    .W(CNT_W)
  ) u_reload (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cap_i(cap),
    .cap_data_i(st_q.cnt),
    .q_o(reload_q)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.mode <= ppm_timer_pkg::mode_reg_t'(`PPM_MODE_RST);
      st_q.presc <= `PPM_PRESC_RST;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign wb_dat_o = st_q.rdata;
  assign wb_ack_o = st_q.ack;
  assign irq_request_flag_o = st_q.irq;

endmodule // pulse_period_width_measure_timer

// File: dv/ppm_timer_sva.sv
// Purpose: Bus and request flag checks at the timer ports
// Assumes: ce_i held high by the bench
// Notes: Bound into the timer top module
`timescale 1ns/1ps
`include "ppm_timer_defines.svh"

module ppm_timer_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and flag
  input wire ppm_timer_pkg::wb_req_t wb_req_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_request_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_prompt_a: assert property (
    wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  reset_quiet_a: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && !irq_request_flag_o)
    else $error("reset left outputs active");
  irq_sticky_a: assert property ($fell(irq_request_flag_o) |->
    $past(wb_req_i.cyc && wb_req_i.we && !wb_req_i.dat[0]
    && wb_req_i.adr == `PPM_ADR_IRQ))
    else $error("request flag dropped alone");
  irq_readback_a: assert property (wb_ack_o && !$past(wb_req_i.we)
    && $past(wb_req_i.adr) == `PPM_ADR_IRQ
    |-> wb_dat_o == {31'h0, $past(irq_request_flag_o)})
    else $error("flag read wrong");
  data_narrow_a: assert property (wb_ack_o && !$past(wb_req_i.we)
    && $past(wb_req_i.adr) == `PPM_ADR_DATA |-> wb_dat_o[31:16] == '0)
    else $error("data read too wide");
  mode_rsv_a: assert property (wb_ack_o && !$past(wb_req_i.we)
    && $past(wb_req_i.adr) == `PPM_ADR_MODE
    |-> wb_dat_o[31:8] == '0 && !wb_dat_o[`PPM_MODE_RSV_BIT])
    else $error("reserved bit set");
  unmapped_zero_a: assert property (wb_ack_o && !$past(wb_req_i.we)
    && $past(wb_req_i.adr) == 8'h20 |-> wb_dat_o == '0)
    else $error("unmapped read not zero");
endmodule // ppm_timer_sva

bind pulse_period_width_measure_timer ppm_timer_sva u_sva (
  .clk_i,
  .rst_i,
  .wb_req_i,
  .wb_dat_o,
  .wb_ack_o,
  .irq_request_flag_o
);

// File: dv/pulse_src.sv
// Purpose: Pulse source on the measured input pin
// Assumes: Level lengths given in clock cycles
// Notes: Idles low so each burst starts with a clean rise
`timescale 1ns/1ps

module pulse_src (
  // Clock and control
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [7:0] hi_i,
  input wire logic [7:0] lo_i,
  // Pin
  output logic pin_o
);
  logic [7:0] cnt_q;

  initial pin_o = 1'b0;

  // Both levels alternate, which width mode must see in turn
  always @(posedge clk_i) begin
    if (!en_i) begin
      cnt_q <= '0;
      pin_o <= 1'b0;
    end else if (cnt_q == (pin_o ? hi_i : lo_i) - 8'h01) begin
      cnt_q <= '0;
      pin_o <= !pin_o;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // pulse_src

// File: dv/pulse_period_width_measure_timer_tb_top.sv
// Purpose: Self-checking bench for the pulse measure timer
// Assumes: Sub clock made from the cycle counter, rising every 8 cycles
// Notes: Divided clocks allow one tick of phase slack
`timescale 1ns/1ps
`include "ppm_timer_defines.svh"

module pulse_period_width_measure_timer_tb_top;
  typedef struct {
    logic [7:0] m;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [15:0] emin;
    logic [15:0] emax;
  } row_t;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic en = 1'b0;
  logic [7:0] hi = 8'h01;
  logic [7:0] lo = 8'h01;
  logic pin;
  logic irq;
  logic wb_ack;
  logic [31:0] wb_dat;
  logic [31:0] rd;
  logic lv;
  logic ok;
  logic [16:0] cyc_q = '0;
  int n_errors = 0;
  int total_checks = 0;
  ppm_timer_pkg::wb_req_t req = '0;
  row_t rows [6] = '{
    '{8'h02, 8'h0a, 8'h14, 16'h001d, 16'h001d},
    '{8'h06, 8'h07, 8'h1e, 16'h0024, 16'h0024},
    '{8'h42, 8'h28, 8'h28, 16'h0009, 16'h000a},
    '{8'h82, 8'h28, 8'h28, 16'h0009, 16'h000a},
    '{8'hc2, 8'h50, 8'h50, 16'h0013, 16'h0014},
    '{8'h0a, 8'h0c, 8'h0c, 16'h000b, 16'h000b}
  };

  pulse_src u_src (.clk_i, .en_i(en), .hi_i(hi), .lo_i(lo), .pin_o(pin));

  pulse_period_width_measure_timer u_dut (
    .clk_i, .rst_i, .ce_i(1'b1), .wb_req_i(req), .wb_dat_o(wb_dat),
    .wb_ack_o(wb_ack), .pulse_input_pin_i(pin),
    .low_speed_sub_clk_i(cyc_q[2]), .irq_request_flag_o(irq));

  initial forever #20 clk_i = ~clk_i;

  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_q <= cyc_q + 17'h0_0001;
    if (cyc_q == 17'h1_5f90) begin
      n_errors++;
      test_done;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'h1, d};
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_dat;
    req <= '0;
  endtask

  task automatic wirq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 70000) begin
      @(posedge clk_i);
      k++;
    end
    chk("irq_wait", irq, 32'h0000_0001);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `PPM_ADR_MODE, '0);
    chk("mode_rst", rd, 32'h0000_0000);
    wb(1'b0, `PPM_ADR_IRQ, '0);
    chk("irq_rst", rd, 32'h0000_0000);
    wb(1'b1, `PPM_ADR_PRESC, 32'h0000_0004);
    foreach (rows[i]) begin
      wb(1'b1, `PPM_ADR_START, '0);
      en <= 1'b0;
      hi <= rows[i].hi;
      lo <= rows[i].lo;
      wb(1'b1, `PPM_ADR_MODE, {24'h00_0000, rows[i].m});
      wb(1'b1, `PPM_ADR_IRQ, '0);
      wb(1'b1, `PPM_ADR_START, 32'h0000_0001);
      en <= 1'b1;
      wirq;
      lv = pin;
      wb(1'b1, `PPM_ADR_IRQ, '0);
      wirq;
      // Handler tells the edge kind from the pin level
      chk("pin_lvl", pin != lv, rows[i].m[3:2] == 2'b10);
      wb(1'b0, `PPM_ADR_DATA, '0);
      ok = rd[15:0] >= rows[i].emin && rd[15:0] <= rows[i].emax;
      chk("measure", ok, 32'h0000_0001);
    end
    // Stopped first, so no later capture can hide a landed write
    wb(1'b1, `PPM_ADR_START, '0);
    en <= 1'b0;
    wb(1'b1, `PPM_ADR_DATA, 32'h0000_1234);
    wb(1'b0, `PPM_ADR_DATA, '0);
    chk("data_wr", rd, 32'h0000_000b);
    // Pin held idle so no edge meets the overflow
    wb(1'b1, `PPM_ADR_MODE, 32'h0000_0002);
    wb(1'b1, `PPM_ADR_IRQ, '0);
    wb(1'b1, `PPM_ADR_START, 32'h0000_0001);
    wirq;
    wb(1'b0, `PPM_ADR_MODE, '0);
    chk("ovf_set", rd, 32'h0000_0022);
    wb(1'b1, `PPM_ADR_MODE, 32'h0000_0002);
    wb(1'b0, `PPM_ADR_MODE, '0);
    chk("ovf_clr", rd, 32'h0000_0002);
    wb(1'b1, `PPM_ADR_IRQ, '0);
    wb(1'b1, `PPM_ADR_MODE, 32'h0000_0002);
    chk("irq_same", irq, 32'h0000_0000);
    wb(1'b1, `PPM_ADR_MODE, 32'h0000_0006);
    chk("irq_chg", irq, 32'h0000_0001);
    wb(1'b1, `PPM_ADR_START, '0);
    wb(1'b1, `PPM_ADR_MODE, 32'h0000_0022);
    wb(1'b0, `PPM_ADR_MODE, '0);
    chk("ovf_ro", rd, 32'h0000_0002);
    wb(1'b0, 8'h20, '0);
    chk("unmapped", rd, 32'h0000_0000);
    // Reset in mid-run must stop the channel and drop the request
    wb(1'b1, `PPM_ADR_START, 32'h0000_0001);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("rst_irq", irq, 32'h0000_0000);
    wb(1'b0, `PPM_ADR_START, '0);
    chk("rst_run", rd, 32'h0000_0000);
    wb(1'b0, `PPM_ADR_MODE, '0);
    chk("rst_mode", rd, 32'h0000_0000);
    test_done;
  end
endmodule // pulse_period_width_measure_timer_tb_top
